// File: src/drpc_defines.svh
// register map, field positions, reset values and timing counts of the dram control block
`ifndef DRPC_DEFINES_SVH
`define DRPC_DEFINES_SVH

`define DRPC_CFG_OFS       4'h0
`define DRPC_STAT_OFS      4'h4
`define DRPC_CFG_RESET     24'h000000
`define DRPC_CFG_WR_MASK   24'hfffb0f

`define DRPC_PRESC_SEL     23
`define DRPC_DIV_HI        22
`define DRPC_DIV_LO        15
`define DRPC_SW_TRIG       14
`define DRPC_CNT_ON        13
`define DRPC_KEEP_STROBES  12
`define DRPC_PAGE_ON       11
`define DRPC_PSIZE_HI      9
`define DRPC_PSIZE_LO      8
`define DRPC_ROW_WS_HI     3
`define DRPC_ROW_WS_LO     2
`define DRPC_COL_WS_HI     1
`define DRPC_COL_WS_LO     0

`define DRPC_PRESC_LAST    6'h3f
`define DRPC_COL_BASE      5'h09
`define DRPC_ROW_WS0       4'h4
`define DRPC_ROW_WS1       4'h8
`define DRPC_ROW_WS2       4'hb
`define DRPC_ROW_WS3       4'hf
`define DRPC_REF_MIN       4'h5

`endif

// File: src/drpc_pkg.sv
// types shared by the dram refresh and page control block
package drpc_pkg;
    typedef enum logic [1:0] {
        DRPC_IDLE = 2'h0,
        DRPC_ROW  = 2'h1,
        DRPC_COL  = 2'h3,
        DRPC_REF  = 2'h2
    } drpc_state_t;

    typedef struct packed {
        logic [23:0] cfg;
        logic [5:0]  presc;
        logic [7:0]  divc;
        logic        per_pend;
        drpc_state_t st;
        logic [3:0]  wcnt;
        logic        page_valid;
        logic [3:0]  page_bank;
        logic [23:0] page_row;
        logic [3:0]  ras_n;
        logic        cas_n;
        logic [23:0] dram_addr;
        logic        acc_done;
        logic        ap_wr;
        logic [3:0]  ap_addr;
        logic [31:0] rdata;
    } drpc_regs_t;
endpackage

// File: src/drpc_ctrl.sv
// dram controller: refresh generation, page hit logic, strobe drive and ahb-lite register slave
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "drpc_defines.svh"

module drpc_ctrl (
    input  wire  logic        mclk,
    input  wire  logic        reset_n,
    // ahb-lite slave
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output       logic        hreadyout,
    output       logic        hresp,
    output       logic [31:0] hrdata,
    // core access request, held until acc_done
    input  wire  logic        acc_req,
    input  wire  logic [23:0] acc_addr,
    input  wire  logic [3:0]  acc_bank,
    output       logic        acc_done,
    // system state
    input  wire  logic        bus_master,
    input  wire  logic        stop_mode,
    output       logic        bus_req,
    // dram pins
    output       logic [3:0]  ras_n_o,
    output       logic [3:0]  ras_oe_n,
    output       logic        cas_n_o,
    output       logic        cas_oe_n,
    output       logic [23:0] dram_addr
);
    import drpc_pkg::*;

    drpc_regs_t q;
    drpc_regs_t d;

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode

    logic        presc_sel;
    logic [7:0]  div_val;
    logic        cnt_on;
    logic        keep_strobes;
    logic        page_on;
    logic [1:0]  psize;
    logic [3:0]  row_ws;
    logic [3:0]  col_ws;
    logic        drive_en;
    logic        cnt_run;
    logic        tick;
    logic        ref_want;
    logic        ref_go;
    logic        acc_go;
    logic        page_hit;
    logic [4:0]  col_bits;
    logic [23:0] col_mask;
    logic [23:0] acc_row;
    logic        ap_take;
    logic        sw_set;
    logic        ref_end;
    logic        mast_q;
    logic        per_hit;

    assign presc_sel    = q.cfg[`DRPC_PRESC_SEL];
    assign div_val      = q.cfg[`DRPC_DIV_HI:`DRPC_DIV_LO];
    assign cnt_on       = q.cfg[`DRPC_CNT_ON];
    assign keep_strobes = q.cfg[`DRPC_KEEP_STROBES];
    assign page_on      = q.cfg[`DRPC_PAGE_ON];
    assign psize        = q.cfg[`DRPC_PSIZE_HI:`DRPC_PSIZE_LO];

    // row miss wait states
    always_comb begin
        unique case (q.cfg[`DRPC_ROW_WS_HI:`DRPC_ROW_WS_LO])
            2'h0: row_ws = `DRPC_ROW_WS0;
            2'h1: row_ws = `DRPC_ROW_WS1;
            2'h2: row_ws = `DRPC_ROW_WS2;
            2'h3: row_ws = `DRPC_ROW_WS3;
        endcase
    end

    // in-page wait states 1..4
    assign col_ws   = {2'h0, q.cfg[`DRPC_COL_WS_HI:`DRPC_COL_WS_LO]} + 4'h1;

    // column width from page size
    assign col_bits = `DRPC_COL_BASE + {3'h0, psize};
    assign col_mask = ~(24'hffffff << col_bits);
    assign acc_row  = acc_addr >> col_bits;

    // strobes driven only while master unless keep is set
    assign drive_en = keep_strobes | bus_master;

    ////////////////////////////////////////////////////////////////////////////
    // refresh request generation

    // stop halts the counter, clearing the prescaler and reloading the divider; wait does not
    assign cnt_run  = cnt_on & ~stop_mode;
    assign tick     = ~presc_sel | (q.presc == `DRPC_PRESC_LAST);

    assign ref_want = q.per_pend | q.cfg[`DRPC_SW_TRIG];
    // only from idle, so running access finishes first
    assign ref_go   = (q.st == DRPC_IDLE) & ref_want & drive_en;
    assign acc_go   = (q.st == DRPC_IDLE) & ~ref_want & acc_req & ~q.acc_done & drive_en;
    assign page_hit = page_on & q.page_valid & (q.page_bank == acc_bank)
                    & (q.page_row == acc_row);
    assign ref_end  = (q.st == DRPC_REF) & (q.wcnt == 4'h0);
    assign per_hit  = cnt_run & tick & (q.divc == 8'h00);
    assign bus_req  = ref_want & ~keep_strobes & ~bus_master;

    assign ap_take  = hsel & htrans[1] & hready;
    assign sw_set   = q.ap_wr & (q.ap_addr == `DRPC_CFG_OFS) & hwdata[`DRPC_SW_TRIG];

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.acc_done = 1'b0;

        // register write in data phase
        if (q.ap_wr && q.ap_addr == `DRPC_CFG_OFS) begin
            d.cfg = hwdata[23:0] & `DRPC_CFG_WR_MASK;
        end
        // hardware clear loses to a same-cycle software set
        if (ref_end && !sw_set) begin
            d.cfg[`DRPC_SW_TRIG] = 1'b0;
        end

        // prescaler and divider
        if (!cnt_run) begin
            d.presc = 6'h00;
            d.divc  = div_val;
        end else begin
            d.presc = presc_sel ? q.presc + 6'h01 : 6'h00;
            if (tick) begin
                if (q.divc == 8'h00) begin
                    d.divc     = div_val;
                    d.per_pend = 1'b1;
                end else begin
                    d.divc = q.divc - 8'h01;
                end
            end
        end

        unique case (q.st)
            DRPC_IDLE: begin
                d.cas_n = 1'b1;
                if (ref_go) begin
                    // cas before ras: cas first, banks closed
                    d.st         = DRPC_REF;
                    d.wcnt       = row_ws;
                    d.cas_n      = 1'b0;
                    d.ras_n      = 4'hf;
                    d.page_valid = 1'b0;
                end else if (acc_go && page_hit) begin
                    d.st        = DRPC_COL;
                    d.wcnt      = col_ws - 4'h1;
                    d.dram_addr = acc_addr & col_mask;
                    d.cas_n     = 1'b0;
                end else if (acc_go) begin
                    d.st         = DRPC_ROW;
                    d.dram_addr  = acc_row;
                    d.ras_n      = ~acc_bank;
                    d.page_valid = 1'b0;
                end else if (!page_on) begin
                    d.ras_n = 4'hf;
                end
            end
            DRPC_ROW: begin
                d.st        = DRPC_COL;
                d.wcnt      = row_ws - 4'h2;
                d.dram_addr = acc_addr & col_mask;
                d.cas_n     = 1'b0;
            end
            DRPC_COL: begin
                if (q.wcnt == 4'h0) begin
                    d.st       = DRPC_IDLE;
                    d.cas_n    = 1'b1;
                    d.acc_done = 1'b1;
                    if (page_on) begin
                        d.page_valid = 1'b1;
                        d.page_bank  = acc_bank;
                        d.page_row   = acc_row;
                    end else begin
                        d.ras_n = 4'hf;
                    end
                end else begin
                    d.wcnt = q.wcnt - 4'h1;
                end
            end
            DRPC_REF: begin
                d.ras_n = 4'h0;
                if (q.wcnt == 4'h0) begin
                    d.st       = DRPC_IDLE;
                    d.ras_n    = 4'hf;
                    d.cas_n    = 1'b1;
                    // a request landing on the last refresh cycle is kept
                    d.per_pend = per_hit;
                end else begin
                    d.wcnt = q.wcnt - 4'h1;
                end
            end
        endcase

        // losing mastership without keep drops the open page, even as an access closes
        if (!keep_strobes && mast_q && !bus_master) begin
            d.page_valid = 1'b0;
        end

        // address phase capture and read data
        d.ap_wr   = ap_take & hwrite;
        d.ap_addr = haddr[3:0];
        if (ap_take && !hwrite) begin
            unique case (haddr[3:0])
                `DRPC_CFG_OFS:  d.rdata = {8'h00, d.cfg};
                `DRPC_STAT_OFS: d.rdata = {20'h00000, q.divc, bus_master, q.page_valid,
                                           q.per_pend, q.st != DRPC_IDLE};
                default:        d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q           <= '0;
            q.cfg       <= `DRPC_CFG_RESET;
            q.st        <= DRPC_IDLE;
            q.ras_n     <= 4'hf;
            q.cas_n     <= 1'b1;
            mast_q      <= 1'b0;
        end else begin
            q      <= d;
            mast_q <= bus_master;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.rdata;
    assign acc_done  = q.acc_done;
    assign ras_n_o   = q.ras_n;
    assign cas_n_o   = q.cas_n;
    assign dram_addr = q.dram_addr;
    assign ras_oe_n  = {4{~drive_en}};
    assign cas_oe_n  = ~drive_en;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic unused_hsize;
    assign unused_hsize = |hsize;

    a_presc_bypass: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.presc != 6'h00) |-> $past(presc_sel))
        else $error("prescaler advanced while bypassed");

    a_req_at_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        (cnt_run && tick && q.divc == 8'h00) |=> (q.per_pend && q.divc == $past(div_val)))
        else $error("no request or reload at counter zero");

    a_div_count: assert property (@(posedge mclk) disable iff (!reset_n)
        (cnt_run && tick && q.divc != 8'h00) |=> (q.divc == $past(q.divc) - 8'h01))
        else $error("divider did not step on tick");

    a_ref_length: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == DRPC_IDLE) ##1 (q.st == DRPC_REF) |-> (q.st == DRPC_REF) [*5])
        else $error("refresh shorter than five cycles");

    a_ref_match: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == DRPC_IDLE && ref_go) |=> (q.wcnt == $past(row_ws)))
        else $error("refresh length differs from row miss length");

    a_sw_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        ($fell(q.cfg[`DRPC_SW_TRIG]) && !$past(q.ap_wr))
        |-> ($past(q.st) == DRPC_REF && $past(q.wcnt) == 4'h0))
        else $error("trigger bit cleared without refresh");

    a_all_ras: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == DRPC_REF && $past(q.st) == DRPC_REF) |-> (q.ras_n == 4'h0 && !q.cas_n))
        else $error("refresh did not assert all ras strobes");

    a_stop_halts: assert property (@(posedge mclk) disable iff (!reset_n)
        (stop_mode && !q.per_pend) |=> !q.per_pend)
        else $error("periodic request raised in stop");

    a_ref_master: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == DRPC_IDLE) ##1 (q.st == DRPC_REF) |-> $past(keep_strobes || bus_master))
        else $error("refresh started without mastership");

    a_tristate: assert property (@(posedge mclk) disable iff (!reset_n)
        (!keep_strobes && !bus_master) |-> (ras_oe_n == 4'hf && cas_oe_n))
        else $error("strobes driven without mastership");

    a_page_lost: assert property (@(posedge mclk) disable iff (!reset_n)
        (!keep_strobes && $fell(bus_master)) |=> !q.page_valid)
        else $error("page kept after mastership loss");

    a_page_off: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == DRPC_IDLE) ##1 (q.st == DRPC_COL) |-> $past(page_on))
        else $error("in-page access with page logic off");

    a_bank_switch: assert property (@(posedge mclk) disable iff (!reset_n)
        (acc_go && q.page_bank != acc_bank) |=> (q.st == DRPC_ROW))
        else $error("bank change not handled as miss");

    a_wait_access: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == DRPC_COL && q.wcnt != 4'h0) |=> (q.st != DRPC_REF))
        else $error("refresh broke into an access");

    a_trig_start: assert property (@(posedge mclk) disable iff (!reset_n)
        (q.st == DRPC_IDLE && q.cfg[`DRPC_SW_TRIG] && drive_en) |=> (q.st == DRPC_REF))
        else $error("triggered refresh did not start");

    a_hit_col: assert property (@(posedge mclk) disable iff (!reset_n)
        (acc_go && page_hit) |=> (q.st == DRPC_COL && !q.cas_n && q.ras_n == $past(q.ras_n)
                                  && q.dram_addr == ($past(acc_addr) & $past(col_mask))))
        else $error("in-page access did not drive column only");

    a_miss_row: assert property (@(posedge mclk) disable iff (!reset_n)
        (acc_go && !page_hit) |=> (q.st == DRPC_ROW && q.ras_n == ~$past(acc_bank)))
        else $error("page miss did not open the row");

    a_cnt_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !cnt_run |=> (q.divc == $past(div_val) && q.presc == 6'h00))
        else $error("refresh counter ran while off");

    a_keep_drive: assert property (@(posedge mclk) disable iff (!reset_n)
        keep_strobes |-> (ras_oe_n == 4'h0 && !cas_oe_n))
        else $error("strobes released with keep set");

    c_periodic: cover property (@(posedge mclk) disable iff (!reset_n)
        cnt_on ##1 (q.st == DRPC_REF));
    c_page_hit: cover property (@(posedge mclk) disable iff (!reset_n)
        acc_go && page_hit);
    c_sw_ref: cover property (@(posedge mclk) disable iff (!reset_n)
        $fell(q.cfg[`DRPC_SW_TRIG]));
    c_keep_ref: cover property (@(posedge mclk) disable iff (!reset_n)
        keep_strobes && !bus_master && q.st == DRPC_REF);
    c_page_loss: cover property (@(posedge mclk) disable iff (!reset_n)
        !keep_strobes && $fell(bus_master) && q.page_valid);

endmodule

// File: verification/drpc_dram_model.sv
// dram bank model: pull-ups on released strobes, refresh detection and spacing
`timescale 1ns/10ps
module drpc_dram_model (
    input  wire logic       mclk,
    input  wire logic [3:0] ras_n_o,
    input  wire logic [3:0] ras_oe_n,
    input  wire logic       cas_n_o,
    input  wire logic       cas_oe_n,
    output      logic [3:0] ras_pin,
    output      logic       cas_pin,
    output      int         ref_cnt,
    output      int         ref_gap
);
    int   now_q  = 0;
    int   last_q = 0;
    logic cas_q  = 1'b1;
    initial begin
        ref_cnt = 0;
        ref_gap = 0;
    end
    // released strobes float high through pull-ups
    assign ras_pin = ras_n_o | ras_oe_n;
    assign cas_pin = cas_n_o | cas_oe_n;
    ////////////////////////////////////////////////////////////////
    // cas falling with every ras high is a cas-before-ras refresh
    always @(posedge mclk) begin
        now_q <= now_q + 1;
        cas_q <= cas_pin;
        if (cas_q === 1'b1 && cas_pin === 1'b0 && ras_pin === 4'hf) begin
            ref_cnt <= ref_cnt + 1;
            ref_gap <= now_q - last_q;
            last_q  <= now_q;
        end
    end
endmodule

// File: verification/drpc_ctrl_tb_top.sv
// self-checking testbench for the dram refresh and page control block
`timescale 1ns/10ps
module drpc_ctrl_tb_top;
    logic        mclk;
    logic        reset_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    wire         hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        acc_req;
    logic [23:0] acc_addr;
    logic [3:0]  acc_bank;
    logic        acc_done;
    logic        bus_master;
    logic        stop_mode;
    logic        bus_req;
    logic [3:0]  ras_n_o;
    logic [3:0]  ras_oe_n;
    logic        cas_n_o;
    logic        cas_oe_n;
    logic [23:0] dram_addr;
    logic [3:0]  ras_pin;
    logic        cas_pin;
    int          ref_cnt;
    int          ref_gap;
    int          errors     = 0;
    int          num_checks = 0;
    int          cycles     = 0;

    drpc_ctrl drpc_ctrl_i (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready, .hreadyout(hready), .hresp, .hrdata, .acc_req, .acc_addr, .acc_bank, .acc_done,
        .bus_master, .stop_mode, .bus_req, .ras_n_o, .ras_oe_n, .cas_n_o, .cas_oe_n, .dram_addr);
    drpc_dram_model drpc_dram_model_i (.mclk, .ras_n_o, .ras_oe_n, .cas_n_o, .cas_oe_n, .ras_pin,
        .cas_pin, .ref_cnt, .ref_gap);

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] cf(logic p, logic [7:0] d, logic [3:0] f, logic [1:0] ps, rw);
        return {8'h00, p, d, f, 1'b0, ps, 4'h0, rw, 2'h0};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rchk(input logic [31:0] a, e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    // latency counted in edges from the taking edge to the one that sees acc_done
    task automatic acc(input logic [23:0] a, input logic [3:0] b, input int e);
        int n;
        n = 0;
        acc_req  <= 1'b1;
        acc_addr <= a;
        acc_bank <= b;
        do begin
            @(posedge mclk);
            n++;
        end while (acc_done !== 1'b1 && n < 40);
        acc_req <= 1'b0;
        @(posedge mclk);
        chk(n, e);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk({ras_n_o, cas_n_o, hresp}, 6'h3e);
        rchk(32'h0, 32'h0);
        wr(32'h0, 32'hff00_0bf0);
        rchk(32'h0, 32'h0000_0b00);
        rchk(32'h8, 32'h0);
        wr(32'h0, 32'h0);
    endtask
    task automatic t_soft;
        int n;
        for (int w = 0; w < 4; w++) begin
            wr(32'h0, cf(0, 8'h00, 4'h8, 2'h0, w[1:0]));
            n = 0;
            repeat (40) begin
                @(posedge mclk);
                if (ras_n_o === 4'h0) n++;
            end
            chk(n, w == 0 ? 4 : w == 1 ? 8 : w == 2 ? 11 : 15);
            rchk(32'h0, cf(0, 8'h00, 4'h0, 2'h0, w[1:0]));
        end
        chk(ref_cnt, 4);
    endtask
    task automatic t_per;
        int c;
        wr(32'h0, cf(0, 8'h09, 4'h4, 2'h0, 2'h0));
        cyc(60);
        chk(ref_gap, 10);
        // counter off first so the divider preloads the new value
        wr(32'h0, cf(1, 8'h01, 4'h0, 2'h0, 2'h0));
        wr(32'h0, cf(1, 8'h01, 4'h4, 2'h0, 2'h0));
        cyc(400);
        chk(ref_gap, 128);
        wr(32'h0, cf(0, 8'h00, 4'h4, 2'h0, 2'h0));
        c = ref_cnt;
        cyc(60);
        chk(ref_gap >= 5 && ref_cnt - c <= 12, 1);
        stop_mode <= 1'b1;
        cyc(10);
        c = ref_cnt;
        cyc(100);
        chk(ref_cnt, c);
        stop_mode <= 1'b0;
        wr(32'h0, 32'h0);
        cyc(10);
        c = ref_cnt;
        cyc(100);
        chk(ref_cnt, c);
    endtask
    task automatic t_master;
        int c;
        bus_master <= 1'b0;
        cyc(2);
        chk({ras_oe_n, cas_oe_n, ras_pin, cas_pin}, 10'h3ff);
        c = ref_cnt;
        wr(32'h0, cf(0, 8'h00, 4'h8, 2'h0, 2'h0));
        cyc(40);
        chk(ref_cnt, c);
        chk(bus_req, 1'b1);
        bus_master <= 1'b1;
        cyc(20);
        chk(ref_cnt, c + 1);
        wr(32'h0, cf(0, 8'h00, 4'h2, 2'h0, 2'h0));
        bus_master <= 1'b0;
        cyc(2);
        chk({ras_oe_n, cas_oe_n}, 5'h00);
        wr(32'h0, cf(0, 8'h00, 4'ha, 2'h0, 2'h0));
        cyc(20);
        chk(ref_cnt, c + 2);
        bus_master <= 1'b1;
        wr(32'h0, 32'h0);
    endtask
    task automatic t_page;
        wr(32'h0, cf(0, 8'h00, 4'h1, 2'h0, 2'h0));
        acc(24'h000100, 4'h2, 6);
        acc(24'h000101, 4'h2, 3);
        acc(24'h000101, 4'h4, 6);
        acc(24'h000301, 4'h4, 6);
        chk({ras_n_o, dram_addr}, {4'hb, 24'h000101});
        wr(32'h0, cf(0, 8'h00, 4'h1, 2'h1, 2'h0));
        acc(24'h000301, 4'h2, 6);
        acc(24'h000101, 4'h2, 3);
        bus_master <= 1'b0;
        cyc(2);
        bus_master <= 1'b1;
        acc(24'h000101, 4'h2, 6);
        wr(32'h0, cf(0, 8'h00, 4'h0, 2'h0, 2'h3));
        acc(24'h000101, 4'h4, 17);
        acc(24'h000101, 4'h4, 17);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            conclude;
        end
    end
    initial begin
        reset_n    = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hwdata     = 32'h0;
        acc_req    = 1'b0;
        acc_addr   = 24'h0;
        acc_bank   = 4'h1;
        bus_master = 1'b1;
        stop_mode  = 1'b0;
        cyc(16);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_soft;
        t_per;
        t_master;
        t_page;
        conclude;
    end
endmodule
